// File: core/radio_config_serial_port.sv
`timescale 1ns/10ps
// Overview of operation
// - Chip select going high mid-access aborts it at once and later clock edges are ignored.
// - After chip select falls the serial output goes low once the chip has settled.
// - Each access opens with a header byte holding read flag, burst flag and 6-bit address.
// - After the reset strobe the serial output goes low again when reset ends, then idle.
// - At power-up the device is reset automatically or manually before configuration.
// - Receive and transmit strobes, or wake-on-radio, enter receive or transmit mode.
// - With wake-on-radio on, the device leaves sleep once, after the wake period, without any command, and then stays in receive.
// - With wake sync select at 0, wake at the wake point and enter receive at the entry point.
// - Two-level frequency keying maps symbol 0 to negative and 1 to positive deviation.
// - On-off keying turns the power amplifier on for bit 1 and off for bit 0.

module radio_config_serial_port #(
    parameter int SETTLE_CYCLES = radio_cfg_pkg::SETTLE_CYCLES,
    parameter int RESET_CYCLES = radio_cfg_pkg::RESET_CYCLES,
    parameter int WAKE_PERIOD_CYCLES = radio_cfg_pkg::WAKE_PERIOD_CYCLES,
    parameter int RX_ENTRY_CYCLES = radio_cfg_pkg::RX_ENTRY_CYCLES
) (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic serial_clk_in,
    input wire logic chip_select_n_in,
    input wire logic serial_in,
    input wire logic tx_data_in,
    output logic serial_out_out,
    output logic rx_active_out,
    output logic tx_active_out,
    output logic sleep_active_out,
    output logic pa_enable_out,
    output logic deviation_positive_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // Link side, clocked by the host's serial clock.

    radio_cfg_pkg::link_frame_s frame_reg;
    radio_cfg_pkg::link_frame_s frame_next;
    radio_cfg_pkg::link_byte_s byte_reg;
    radio_cfg_pkg::link_byte_s byte_next;

    always_comb begin
        frame_next = frame_reg;
        byte_next = byte_reg;
        frame_next.shift = {frame_reg.shift[radio_cfg_pkg::BYTE_W-3:0], serial_in};
        frame_next.bit_cnt = frame_reg.bit_cnt + 3'h1;
        if (frame_reg.bit_cnt == radio_cfg_pkg::LAST_BIT) begin
            byte_next.data = {frame_reg.shift, serial_in};
            byte_next.is_header = frame_reg.first;
            byte_next.toggle = ~byte_reg.toggle;
            frame_next.first = 1'b0;
        end
    end

    // The serial clock stops outside accesses, so the abort must act without
    // an edge: chip select high clears the framing asynchronously.
    // abort on chip select high
    always_ff @(posedge serial_clk_in or posedge chip_select_n_in) begin
        if (chip_select_n_in) begin
            frame_reg <= '0;
            frame_reg.first <= 1'b1;
        end else begin
            frame_reg <= frame_next;
        end
    end

    // The byte toggle survives chip select so a byte finished just before
    // chip select rises still reaches the core side.
    always_ff @(posedge serial_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            byte_reg <= '0;
        end else begin
            byte_reg <= byte_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Core side, clocked by the reference clock.

    radio_cfg_pkg::core_state_s core_reg;
    radio_cfg_pkg::core_state_s core_next;

    logic cs_active;
    logic byte_evt;
    radio_cfg_pkg::header_s hdr;

    always_comb begin
        core_next = core_reg;
        core_next.csn_s1 = chip_select_n_in;
        core_next.csn_s2 = core_reg.csn_s1;
        core_next.csn_seen = core_reg.csn_s2;
        core_next.tog_s1 = byte_reg.toggle;
        core_next.tog_s2 = core_reg.tog_s1;
        core_next.tog_seen = core_reg.tog_s2;
        cs_active = ~core_reg.csn_s2;
        byte_evt = core_reg.tog_s2 != core_reg.tog_seen;
        // The byte is stable for eight serial clocks after its toggle flips,
        // far longer than the two-stage crossing of the toggle.
        hdr = radio_cfg_pkg::header_s'(byte_reg.data);

        if (!cs_active) begin
            core_next.hdr_valid = 1'b0;
        end

        unique case (core_reg.state)
            radio_cfg_pkg::st_settle: begin
                if (core_reg.cnt == '0) begin
                    core_next.state = radio_cfg_pkg::st_idle;
                end else begin
                    core_next.cnt = core_reg.cnt - 1'b1;
                end
            end
            radio_cfg_pkg::st_idle, radio_cfg_pkg::st_rx, radio_cfg_pkg::st_tx: begin
            end
            radio_cfg_pkg::st_sleep: begin
                // Besides the wake-on-radio timer, only a fresh fall of chip select wakes the chip: the strobe that
                // sends it to sleep arrives with chip select still low.
                if (cs_active && core_reg.csn_seen) begin
                    core_next.state = radio_cfg_pkg::st_settle;
                    core_next.cnt = radio_cfg_pkg::CNT_W'(SETTLE_CYCLES - 1);
                    core_next.wor_on = 1'b0;
                end else if (core_reg.wor_on) begin
                    if (core_reg.cnt != '0) begin
                        core_next.cnt = core_reg.cnt - 1'b1;
                    end else if (core_reg.pkt_ctrl[radio_cfg_pkg::WAKE_SYNC_SELECT_BIT]) begin
                        core_next.state = radio_cfg_pkg::st_rx;
                    end else begin
                        core_next.state = radio_cfg_pkg::st_wake;
                        core_next.cnt = radio_cfg_pkg::CNT_W'(RX_ENTRY_CYCLES - 1);
                    end
                end
            end
            radio_cfg_pkg::st_wake: begin
                if (core_reg.cnt == '0) begin
                    core_next.state = radio_cfg_pkg::st_rx;
                end else begin
                    core_next.cnt = core_reg.cnt - 1'b1;
                end
            end
            default: begin
                core_next.state = radio_cfg_pkg::st_settle;
            end
        endcase

        if (byte_evt && byte_reg.is_header) begin
            if (!hdr.read && hdr.addr >= radio_cfg_pkg::STROBE_MIN) begin
                if (hdr.addr == radio_cfg_pkg::STROBE_RESET) begin
                    core_next.state = radio_cfg_pkg::st_settle;
                    core_next.cnt = radio_cfg_pkg::CNT_W'(RESET_CYCLES - 1);
                    core_next.pkt_ctrl = radio_cfg_pkg::PACKET_CONTROL_ONE_RST;
                    core_next.mod_cfg = radio_cfg_pkg::MOD_CFG_RST;
                    core_next.wor_on = 1'b0;
                end else if (core_reg.state != radio_cfg_pkg::st_settle) begin
                    if (hdr.addr == radio_cfg_pkg::STROBE_RX) begin
                        core_next.state = radio_cfg_pkg::st_rx;
                    end else if (hdr.addr == radio_cfg_pkg::STROBE_TX) begin
                        core_next.state = radio_cfg_pkg::st_tx;
                    end else if (hdr.addr == radio_cfg_pkg::STROBE_IDLE) begin
                        core_next.state = radio_cfg_pkg::st_idle;
                    end else if (hdr.addr == radio_cfg_pkg::STROBE_WOR ||
                                 hdr.addr == radio_cfg_pkg::STROBE_SLEEP) begin
                        core_next.state = radio_cfg_pkg::st_sleep;
                        core_next.wor_on = hdr.addr == radio_cfg_pkg::STROBE_WOR;
                        core_next.cnt = radio_cfg_pkg::CNT_W'(WAKE_PERIOD_CYCLES - 1);
                    end
                end
            end else begin
                core_next.hdr_valid = 1'b1;
                core_next.wr = ~hdr.read;
                core_next.burst = hdr.burst;
                core_next.addr = hdr.addr;
            end
        end else if (byte_evt && core_reg.hdr_valid) begin
            if (core_reg.wr) begin
                if (core_reg.addr == radio_cfg_pkg::ADDR_PACKET_CONTROL_ONE) begin
                    core_next.pkt_ctrl = byte_reg.data;
                end
                if (core_reg.addr == radio_cfg_pkg::ADDR_MOD_CFG) begin
                    core_next.mod_cfg = byte_reg.data;
                end
            end
            // Without burst only one data byte belongs to the access.
            if (core_reg.burst) begin
                core_next.addr = core_reg.addr + 6'h01;
            end else begin
                core_next.hdr_valid = 1'b0;
            end
        end

        core_next.so = ~cs_active || core_reg.state == radio_cfg_pkg::st_settle ||
                       core_reg.state == radio_cfg_pkg::st_sleep;

        core_next.rx_on = core_reg.state == radio_cfg_pkg::st_rx;
        core_next.tx_on = core_reg.state == radio_cfg_pkg::st_tx;
        core_next.sleep_on = core_reg.state == radio_cfg_pkg::st_sleep;
        core_next.pa_on = 1'b0;
        core_next.dev_pos = 1'b0;
        if (core_reg.state == radio_cfg_pkg::st_tx) begin
            if (core_reg.mod_cfg[radio_cfg_pkg::OOK_SELECT_BIT]) begin
                core_next.pa_on = tx_data_in;
            end else begin
                core_next.pa_on = 1'b1;
                core_next.dev_pos = tx_data_in;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            core_reg <= '0;
            core_reg.csn_s1 <= 1'b1;
            core_reg.csn_s2 <= 1'b1;
            core_reg.csn_seen <= 1'b1;
            core_reg.state <= radio_cfg_pkg::st_settle;
            core_reg.cnt <= radio_cfg_pkg::CNT_W'(SETTLE_CYCLES - 1);
            core_reg.pkt_ctrl <= radio_cfg_pkg::PACKET_CONTROL_ONE_RST;
            core_reg.mod_cfg <= radio_cfg_pkg::MOD_CFG_RST;
            core_reg.so <= 1'b1;
        end else begin
            core_reg <= core_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs, each straight from a core flip-flop.

    assign serial_out_out = core_reg.so;
    assign rx_active_out = core_reg.rx_on;
    assign tx_active_out = core_reg.tx_on;
    assign sleep_active_out = core_reg.sleep_on;
    assign pa_enable_out = core_reg.pa_on;
    assign deviation_positive_out = core_reg.dev_pos;

endmodule : radio_config_serial_port

// File: inc/radio_cfg_pkg.sv
package radio_cfg_pkg;

    // Core clock rate in MHz, used to turn times into cycle counts.
    localparam int CLK_MHZ = 25;

    // Settling time of regulator and crystal before the port reports ready.
    localparam int SETTLE_TIME_US = 64;
    localparam int SETTLE_CYCLES = SETTLE_TIME_US * CLK_MHZ;
    // Internal reset time after a reset strobe.
    localparam int RESET_TIME_US = 32;
    localparam int RESET_CYCLES = RESET_TIME_US * CLK_MHZ;
    // Sleep time from sleep entry to the wake time point.
    localparam int WAKE_PERIOD_US = 1000;
    localparam int WAKE_PERIOD_CYCLES = WAKE_PERIOD_US * CLK_MHZ;
    // Time from the wake time point to the receive entry time point.
    localparam int RX_ENTRY_US = 200;
    localparam int RX_ENTRY_CYCLES = RX_ENTRY_US * CLK_MHZ;

    localparam int CNT_W = 24;
    localparam int ADDR_W = 6;
    localparam int BYTE_W = 8;
    localparam logic [2:0] LAST_BIT = 3'h7;

    // Header byte layout: read flag, burst flag, address.
    typedef struct packed {
        logic read;
        logic burst;
        logic [ADDR_W-1:0] addr;
    } header_s;

    // Command strobes are single header bytes with these addresses.
    localparam logic [ADDR_W-1:0] STROBE_MIN = 6'h30;
    localparam logic [ADDR_W-1:0] STROBE_RESET = 6'h30;
    localparam logic [ADDR_W-1:0] STROBE_RX = 6'h31;
    localparam logic [ADDR_W-1:0] STROBE_TX = 6'h32;
    localparam logic [ADDR_W-1:0] STROBE_IDLE = 6'h33;
    localparam logic [ADDR_W-1:0] STROBE_WOR = 6'h34;
    localparam logic [ADDR_W-1:0] STROBE_SLEEP = 6'h35;

    // Configuration bytes.
    localparam logic [ADDR_W-1:0] ADDR_PACKET_CONTROL_ONE = 6'h07;
    localparam logic [ADDR_W-1:0] ADDR_MOD_CFG = 6'h08;
    localparam int WAKE_SYNC_SELECT_BIT = 3;
    localparam int OOK_SELECT_BIT = 0;
    localparam logic [BYTE_W-1:0] PACKET_CONTROL_ONE_RST = 8'h00;
    localparam logic [BYTE_W-1:0] MOD_CFG_RST = 8'h00;

    typedef enum logic [2:0] {
        st_settle,
        st_idle,
        st_rx,
        st_tx,
        st_sleep,
        st_wake
    } radio_state_e;

    // Link side: bit framing, cleared whenever chip select is high.
    typedef struct packed {
        logic [2:0] bit_cnt;
        logic [BYTE_W-2:0] shift;
        logic first;
    } link_frame_s;

    // Link side: last completed byte and its event toggle.
    typedef struct packed {
        logic toggle;
        logic is_header;
        logic [BYTE_W-1:0] data;
    } link_byte_s;

    typedef struct packed {
        logic csn_s1;
        logic csn_s2;
        logic csn_seen;
        logic tog_s1;
        logic tog_s2;
        logic tog_seen;
        radio_state_e state;
        logic [CNT_W-1:0] cnt;
        logic wor_on;
        logic hdr_valid;
        logic wr;
        logic burst;
        logic [ADDR_W-1:0] addr;
        logic [BYTE_W-1:0] pkt_ctrl;
        logic [BYTE_W-1:0] mod_cfg;
        logic so;
        logic rx_on;
        logic tx_on;
        logic sleep_on;
        logic pa_on;
        logic dev_pos;
    } core_state_s;

endpackage : radio_cfg_pkg

// File: tb/radio_cfg_props.sv
`timescale 1ns/10ps
module radio_cfg_props (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic serial_clk_in,
    input wire logic chip_select_n_in,
    input wire logic serial_in,
    input wire logic tx_data_in,
    input wire logic serial_out_out,
    input wire logic rx_active_out,
    input wire logic tx_active_out,
    input wire logic sleep_active_out,
    input wire logic pa_enable_out,
    input wire logic deviation_positive_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);
    ////////////////////////////////////////////////////////////////////////////
    a_reset_outs: assert property (
        disable iff (1'b0) !rst_b_in |=> serial_out_out && !rx_active_out
        && !tx_active_out && !sleep_active_out && !pa_enable_out)
        else $error("outputs not at reset level");
    a_cs_high_so: assert property (
        chip_select_n_in [*4] |-> serial_out_out) else $error("ready shown while deselected");
    a_modes_onehot: assert property (
        $onehot0({rx_active_out, tx_active_out, sleep_active_out}))
        else $error("more than one mode active");
    // A deselected port must not move the radio out of transmit or receive mode.
    a_tx_holds: assert property (
        chip_select_n_in [*6] ##0 tx_active_out |=> tx_active_out)
        else $error("transmit left without a command");
    a_rx_holds: assert property (
        chip_select_n_in [*6] ##0 rx_active_out |=> rx_active_out)
        else $error("receive left without a command");
    a_keying_map: assert property (
        tx_active_out && $past(tx_active_out) |-> pa_enable_out == $past(tx_data_in)
        || (pa_enable_out && deviation_positive_out == $past(tx_data_in)))
        else $error("keying does not follow data");
    a_pa_off_idle: assert property (
        !tx_active_out && !$past(tx_active_out) |-> !pa_enable_out)
        else $error("amplifier on outside transmit");
    a_sleep_min: assert property (
        $rose(sleep_active_out) && chip_select_n_in |-> sleep_active_out [*8])
        else $error("sleep left too early");
endmodule : radio_cfg_props

// File: tb/host_model.sv
`timescale 1ns/10ps
module host_model (
    input wire logic so_in,
    output logic sclk_out,
    output logic cs_n_out,
    output logic si_out
);
    initial begin
        // Start just after time zero so the pins make clean edges that clear the link side.
        #1;
        sclk_out = 1'b1;
        cs_n_out = 1'b1;
        si_out = 1'b0;
    end
    task automatic wait_so(input logic lvl, output logic ok);
        for (int i = 0; i < 400 && so_in !== lvl; i++) #20;
        ok = (so_in === lvl);
    endtask : wait_so
    task automatic select(output logic ok);
        cs_n_out = 1'b0;
        wait_so(1'b0, ok);
    endtask : select
    task automatic send_bits(input logic [7:0] b, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            sclk_out = 1'b0;
            si_out = b[i];
            #80;
            sclk_out = 1'b1;
            #80;
        end
    endtask : send_bits
    // The data line has no pull, so it shows garbage once released.
    task automatic release_bus();
        #20 cs_n_out = 1'b1;
        si_out = ~si_out;
    endtask : release_bus
    task automatic manual_reset(output logic ok);
        logic ok_a, ok_b, ok_c;
        sclk_out = 1'b1;
        si_out = 1'b0;
        cs_n_out = 1'b0;
        #1us cs_n_out = 1'b1;
        #41us select(ok_a);
        send_bits({2'b00, radio_cfg_pkg::STROBE_RESET}, 8);
        wait_so(1'b1, ok_b);
        wait_so(1'b0, ok_c);
        release_bus();
        ok = ok_a & ok_b & ok_c;
    endtask : manual_reset
endmodule : host_model

// File: tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    logic clk = 1'b0, rst_b = 1'b0, tx_data = 1'b0, ok;
    logic sclk, cs_n, si, so, rx_act, tx_act, sleep_act, pa_en, dev_pos;
    int num_errors = 0, compares = 0, n;
    always #20 clk = ~clk;
    radio_config_serial_port #(.SETTLE_CYCLES(8), .RESET_CYCLES(8),
        .WAKE_PERIOD_CYCLES(20), .RX_ENTRY_CYCLES(10)) dut_u (.ref_clk_in(clk),
        .rst_b_in(rst_b), .serial_clk_in(sclk), .chip_select_n_in(cs_n), .serial_in(si),
        .tx_data_in(tx_data), .serial_out_out(so), .rx_active_out(rx_act),
        .tx_active_out(tx_act), .sleep_active_out(sleep_act), .pa_enable_out(pa_en),
        .deviation_positive_out(dev_pos));
    host_model host_u (.so_in(so), .sclk_out(sclk), .cs_n_out(cs_n), .si_out(si));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic seen, input logic exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
        end
    endtask : check
    task automatic close_out();
        if (num_errors == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : close_out
    task automatic cycles(input int k);
        repeat (k) @(posedge clk);
        #2;
    endtask : cycles
    task automatic access(input logic [7:0] hdr, d0, d1, input int nb, input int tail);
        host_u.select(ok);
        check("ready", ok, 1'b1);
        host_u.send_bits(hdr, 8);
        if (nb > 1) host_u.send_bits(d0, 8);
        if (nb > 2) host_u.send_bits(d1, 8);
        host_u.release_bus();
        cycles(tail);
    endtask : access
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        cycles(5);
        rst_b = 1'b1;
        cycles(4);
        check("so idle", so, 1'b1);
        host_u.manual_reset(ok);
        check("reset seq", ok, 1'b1);
        cycles(2);
        check("idle", rx_act | tx_act | sleep_act, 1'b0);
        access({2'b00, radio_cfg_pkg::STROBE_TX}, 8'h00, 8'h00, 1, 6);
        check("tx mode", tx_act, 1'b1);
        access(8'h08, 8'h00, 8'h00, 2, 6);
        for (int v = 0; v < 2; v++) begin
            tx_data = v[0];
            cycles(2);
            check("fsk pa", pa_en, 1'b1);
            check("fsk dev", dev_pos, v[0]);
        end
        // Burst header: packet control at 0x07, then on-off keying at 0x08.
        access(8'h47, 8'h00, 8'h01, 3, 6);
        for (int v = 0; v < 2; v++) begin
            tx_data = ~v[0];
            cycles(2);
            check("ook pa", pa_en, ~v[0]);
        end
        host_u.select(ok);
        host_u.send_bits(8'hFF, 4);
        host_u.release_bus();
        cycles(4);
        check("abort", tx_act, 1'b1);
        access({2'b00, radio_cfg_pkg::STROBE_RX}, 8'h00, 8'h00, 1, 6);
        check("rx mode", rx_act, 1'b1);
        access({2'b00, radio_cfg_pkg::STROBE_WOR}, 8'h00, 8'h00, 1, 0);
        for (n = 0; n < 10 && sleep_act !== 1'b1; n++) cycles(1);
        for (n = 0; n < 60 && sleep_act === 1'b1; n++) cycles(1);
        check("sleep span", n >= 19 && n <= 21, 1'b1);
        for (n = 0; n < 60 && rx_act !== 1'b1; n++) cycles(1);
        check("rx entry gap", n >= 9 && n <= 11, 1'b1);
        // Wake sync select set: receive starts at the wake point itself.
        access(8'h07, 8'h08, 8'h00, 2, 6);
        access({2'b00, radio_cfg_pkg::STROBE_WOR}, 8'h00, 8'h00, 1, 0);
        for (n = 0; n < 10 && sleep_act !== 1'b1; n++) cycles(1);
        for (n = 0; n < 60 && sleep_act === 1'b1; n++) cycles(1);
        check("sync sleep span", n >= 19 && n <= 21, 1'b1);
        check("sync rx entry", rx_act, 1'b1);
        access({2'b00, radio_cfg_pkg::STROBE_IDLE}, 8'h00, 8'h00, 1, 6);
        check("idle strobe", rx_act | tx_act | sleep_act, 1'b0);
        access({2'b00, radio_cfg_pkg::STROBE_SLEEP}, 8'h00, 8'h00, 1, 40);
        check("plain sleep", sleep_act, 1'b1);
        host_u.select(ok);
        check("wake ready", ok, 1'b1);
        check("woken", sleep_act, 1'b0);
        host_u.release_bus();
        cycles(2);
        close_out();
    end
    initial begin
        #500us;
        num_errors++;
        close_out();
    end
endmodule : tb_top
bind radio_config_serial_port radio_cfg_props props_u (.ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in), .serial_clk_in(serial_clk_in), .chip_select_n_in(chip_select_n_in),
    .serial_in(serial_in), .tx_data_in(tx_data_in), .serial_out_out(serial_out_out),
    .rx_active_out(rx_active_out), .tx_active_out(tx_active_out),
    .sleep_active_out(sleep_active_out), .pa_enable_out(pa_enable_out),
    .deviation_positive_out(deviation_positive_out));
